// [design/i2cs_sync_serial_slave.sv]
// Operation
// RL1: when enabled, wait for start, then shift eight bits into rx_shift_register
// RL2: sample each data bit on rising bus clock
// RL3: compare shift bits 7:1 with own address at eighth clock fall
// RL4: match with buffer-full and overflow clear: load buffer, set full, acknowledge
// RL5: set irq flag bit 3 at ninth clock fall; interrupt only if enabled
// RL6: buffer full or overflow: no transfer, no acknowledge, irq flag still set
// RL7: ten-bit first byte is 11110, two upper address bits, write bit
// RL8: each ten-bit address byte sets irq, full, update flag; address write releases (a high byte with the read bit leaves update clear)
// RL9: reading the receive buffer clears buffer-full
// RL10: software loads low then high address byte, reads buffer, clears flag
// RL11: remote master signals write in first ten-bit byte
// RL12: matching address with write bit clears rw status, loads buffer
// RL13: irq flag raised per data byte; software clears it
// RL14: start/stop seen cleared on reset or disable, updated on conditions
// RL15: firmware master takes bus on stop seen, or both bits clear
// RL16: master lines driven only low through direction bits 4:3
// RL17: master support sets irq on start, stop and every byte
// RL18: master works with slave active or mode 1011 keeping slave idle
// RL19: interrupt enabled while bus busy fires at the stop
// RL20: firmware checks data line when outputting high, releases on loss
// RL21: slave keeps receiving after lost arbitration and acknowledges if addressed
// RL22: software keeps sample-phase and clock-edge bits clear in two-wire mode
// RL23: start is data falling with clock high; stop is data rising
//
// Decided for this implementation: the APB slave port.
module i2cs_sync_serial_slave (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // word-aligned decode; the two low address bits must be zero
    function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
        reg_hit = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
    endfunction : reg_hit

    // anything outside the map answers with an error, writes dropped
    function automatic logic any_hit(input logic [11:0] a);
        any_hit = reg_hit(a, i2cs_pkg::IDX_GIC) || reg_hit(a, i2cs_pkg::IDX_PFLAGS)
               || reg_hit(a, i2cs_pkg::IDX_RBUF) || reg_hit(a, i2cs_pkg::IDX_CTRL)
               || reg_hit(a, i2cs_pkg::IDX_PDIR) || reg_hit(a, i2cs_pkg::IDX_PEN)
               || reg_hit(a, i2cs_pkg::IDX_OADDR) || reg_hit(a, i2cs_pkg::IDX_STAT);
    endfunction : any_hit

    i2cs_pkg::i2cs_state_t r;
    i2cs_pkg::i2cs_state_t n;
    logic                  scl_s;
    logic                  scl_p;
    logic                  sda_s;
    logic                  sda_p;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_det;
    logic                  stop_det;
    logic                  enabled;
    logic                  slave_on;
    logic                  tenbit;
    logic                  ss_irq;
    logic                  master_idle;
    logic                  acc;
    logic                  can_take;
    logic                  hi_match;
    logic [7:0]            stat_rd;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    i2cs_pin_sync u_scl_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (scl_in),
        .level   (scl_s),
        .prev    (scl_p)
    );

    i2cs_pin_sync u_sda_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (sda_in),
        .level   (sda_s),
        .prev    (sda_p)
    );

    // bus events and decoded mode
    assign scl_rise    = scl_s && !scl_p;
    assign scl_fall    = !scl_s && scl_p;
    assign start_det   = scl_s && scl_p && sda_p && !sda_s; // RL23
    assign stop_det    = scl_s && scl_p && !sda_p && sda_s; // RL23
    assign enabled     = r.ctrl[i2cs_pkg::EN_BIT];
    assign master_idle = r.ctrl[3:0] == i2cs_pkg::MODE_MASTER_IDLE;
    assign tenbit      = (r.ctrl[3:0] == i2cs_pkg::MODE_10BIT) || (r.ctrl[3:0] == i2cs_pkg::MODE_10BIT_SS);
    assign slave_on    = enabled && (tenbit || r.ctrl[3:0] == i2cs_pkg::MODE_7BIT
                                    || r.ctrl[3:0] == i2cs_pkg::MODE_7BIT_SS); // RL18
    assign ss_irq      = enabled && (master_idle || r.ctrl[3:0] == i2cs_pkg::MODE_7BIT_SS
                                    || r.ctrl[3:0] == i2cs_pkg::MODE_10BIT_SS);
    assign acc         = psel && penable && r.pready;
    assign can_take    = !r.bf && !r.ctrl[i2cs_pkg::OV_BIT];
    assign hi_match    = (r.sr[7:3] == i2cs_pkg::TENBIT_PREFIX) && (r.sr[2:1] == r.oaddr[2:1]); // RL7
    assign stat_rd     = {r.smp_cke, r.da, r.stop_seen, r.start_seen, r.rw, r.ua, r.bf};

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // software effects first, hardware sets after, so a set wins a clear
    always_comb begin
        n         = r;
        n.pready  = psel && penable && !r.pready;
        n.pslverr = psel && penable && !r.pready && !any_hit(paddr);
        // read data is registered, so pready waits one cycle for it
        if (psel && penable && !r.pready) begin
            n.prdata = 32'h0000_0000;
            if (reg_hit(paddr, i2cs_pkg::IDX_GIC))    n.prdata[7:0] = r.gic;
            if (reg_hit(paddr, i2cs_pkg::IDX_PFLAGS)) n.prdata[7:0] = r.pflags;
            if (reg_hit(paddr, i2cs_pkg::IDX_RBUF))   n.prdata[7:0] = r.rbuf;
            if (reg_hit(paddr, i2cs_pkg::IDX_CTRL))   n.prdata[7:0] = r.ctrl;
            if (reg_hit(paddr, i2cs_pkg::IDX_PDIR))   n.prdata[7:0] = r.pdir;
            if (reg_hit(paddr, i2cs_pkg::IDX_PEN))    n.prdata[7:0] = r.pen;
            if (reg_hit(paddr, i2cs_pkg::IDX_OADDR))  n.prdata[7:0] = r.oaddr;
            if (reg_hit(paddr, i2cs_pkg::IDX_STAT))   n.prdata[7:0] = stat_rd;
        end
        if (acc && pwrite) begin
            if (reg_hit(paddr, i2cs_pkg::IDX_GIC))    n.gic     = pwdata[7:0];
            if (reg_hit(paddr, i2cs_pkg::IDX_PFLAGS)) n.pflags  = pwdata[7:0]; // RL13
            if (reg_hit(paddr, i2cs_pkg::IDX_RBUF))   n.rbuf    = pwdata[7:0];
            if (reg_hit(paddr, i2cs_pkg::IDX_CTRL))   n.ctrl    = pwdata[7:0];
            if (reg_hit(paddr, i2cs_pkg::IDX_PDIR))   n.pdir    = pwdata[7:0];
            if (reg_hit(paddr, i2cs_pkg::IDX_PEN))    n.pen     = pwdata[7:0];
            if (reg_hit(paddr, i2cs_pkg::IDX_STAT))   n.smp_cke = pwdata[7:6];
            if (reg_hit(paddr, i2cs_pkg::IDX_OADDR)) begin
                n.oaddr = pwdata[7:0];
                n.ua    = 1'b0; // RL8
                n.hold  = 1'b0; // RL8
            end
        end
        if (acc && !pwrite && reg_hit(paddr, i2cs_pkg::IDX_RBUF)) begin
            n.bf = 1'b0; // RL9
        end

        // bus side
        if (!enabled) begin
            n.start_seen = 1'b0; // RL14
            n.stop_seen  = 1'b0; // RL14
            n.state      = i2cs_pkg::SL_IDLE;
            n.cnt        = 4'h0;
            n.ack        = 1'b0;
            n.hold       = 1'b0;
            n.armed      = 1'b0;
        end else if (start_det) begin
            n.start_seen = 1'b1; // RL14
            n.stop_seen  = 1'b0;
            n.cnt        = 4'h0;
            n.ack        = 1'b0;
            n.state      = slave_on ? i2cs_pkg::SL_ADDR : i2cs_pkg::SL_IDLE; // RL1
            if (ss_irq) n.pflags[i2cs_pkg::IRQ_BIT] = 1'b1; // RL17
        end else if (stop_det) begin
            n.stop_seen  = 1'b1; // RL14
            n.start_seen = 1'b0;
            n.state      = i2cs_pkg::SL_IDLE;
            n.ack        = 1'b0;
            n.armed      = 1'b0;
            if (ss_irq) n.pflags[i2cs_pkg::IRQ_BIT] = 1'b1; // RL19
        end else begin
            if (scl_rise && r.cnt < i2cs_pkg::ACK_CLOCK) begin
                n.cnt = r.cnt + 4'h1;
                if (r.cnt < i2cs_pkg::BYTE_BITS) n.sr = {r.sr[6:0], sda_s}; // RL2
            end
            // eighth clock fall: address compare and byte decision
            if (scl_fall && r.cnt == i2cs_pkg::BYTE_BITS) begin
                n.mine = r.state != i2cs_pkg::SL_IDLE;
                case (r.state)
                    i2cs_pkg::SL_ADDR: begin
                        n.da    = 1'b0;
                        n.state = i2cs_pkg::SL_IDLE;
                        if (tenbit && hi_match && (!r.sr[0] || r.armed)) begin
                            n.rw  = r.sr[0]; // RL11
                            n.bf  = 1'b1; // RL8
                            n.ack = can_take; // RL21
                            if (can_take) n.rbuf = r.sr;
                            if (!r.sr[0]) begin
                                n.ua    = 1'b1; // RL8
                                n.state = i2cs_pkg::SL_ADDR_LOW;
                            end
                        end else if (!tenbit && r.sr[7:1] == r.oaddr[7:1]) begin // RL3
                            n.rw = r.sr[0]; // RL12
                            if (can_take) begin
                                n.rbuf = r.sr; // RL4
                                n.bf   = 1'b1; // RL4
                                n.ack  = 1'b1; // RL4
                            end
                            if (!r.sr[0]) n.state = i2cs_pkg::SL_DATA;
                        end else begin
                            n.mine = 1'b0;
                        end
                    end
                    i2cs_pkg::SL_ADDR_LOW: begin
                        if (r.sr == r.oaddr) begin
                            n.ua    = 1'b1; // RL8
                            n.bf    = 1'b1; // RL8
                            n.ack   = can_take;
                            n.armed = 1'b1;
                            n.state = i2cs_pkg::SL_DATA;
                            if (can_take) n.rbuf = r.sr;
                        end else begin
                            n.state = i2cs_pkg::SL_IDLE;
                            n.mine  = 1'b0;
                        end
                    end
                    i2cs_pkg::SL_DATA: begin
                        n.da = 1'b1;
                        if (can_take) begin
                            n.rbuf = r.sr; // RL4
                            n.bf   = 1'b1;
                            n.ack  = 1'b1;
                        end else if (r.bf) begin
                            n.ctrl[i2cs_pkg::OV_BIT] = 1'b1; // RL6
                        end
                    end
                    default: n.mine = 1'b0;
                endcase
            end
            // ninth clock fall: end of byte
            if (scl_fall && r.cnt == i2cs_pkg::ACK_CLOCK) begin
                n.cnt = 4'h0;
                n.ack = 1'b0;
                if (r.mine || ss_irq) n.pflags[i2cs_pkg::IRQ_BIT] = 1'b1; // RL5
                if (r.ua) n.hold = 1'b1; // clock stretch until address reload
                n.mine = 1'b0;
            end
        end

        // slave parked outside slave modes; a transfer cut by a mode change is dropped
        if (!slave_on) begin
            n.state = i2cs_pkg::SL_IDLE; // RL18
            n.ack   = 1'b0;
        end

        // open-drain lines only ever pull low
        n.line_o = 1'b0;
        n.scl_oe = n.hold || !n.pdir[i2cs_pkg::SCL_DIR_BIT]; // RL16
        n.sda_oe = n.ack || !n.pdir[i2cs_pkg::SDA_DIR_BIT]; // RL16
        n.irq    = n.pflags[i2cs_pkg::IRQ_BIT] && n.pen[i2cs_pkg::IRQ_BIT]
                && n.gic[i2cs_pkg::PEIE_BIT] && n.gic[i2cs_pkg::GIE_BIT]; // RL5
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r        <= '0;
            r.gic    <= i2cs_pkg::RST_GIC;
            r.pflags <= i2cs_pkg::RST_PFLAGS;
            r.rbuf   <= i2cs_pkg::RST_RBUF;
            r.ctrl   <= i2cs_pkg::RST_CTRL;
            r.pdir   <= i2cs_pkg::RST_PDIR;
            r.pen    <= i2cs_pkg::RST_PEN;
            r.oaddr  <= i2cs_pkg::RST_OADDR;
            r.state  <= i2cs_pkg::SL_IDLE;
        end else begin
            r <= n;
        end
    end

    // every output comes straight from the state register
    assign prdata  = r.prdata;
    assign pready  = r.pready;
    assign pslverr = r.pslverr;
    assign scl_out = r.line_o;
    assign sda_out = r.line_o;
    assign scl_oe  = r.scl_oe;
    assign sda_oe  = r.sda_oe;
    assign irq     = r.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // the ninth-fall, full-buffer and sampling antecedents exclude start and stop, which override the byte logic

    irq_ninth_fall_a: assert property ( // RL5
        (enabled && scl_fall && r.cnt == 4'h9 && r.mine && !start_det && !stop_det)
        |=> r.pflags[3]
    ) else $error("irq flag not set at ninth clock fall");

    ack_loads_buffer_a: assert property ( // RL4
        $rose(r.ack) |-> r.bf && !$past(r.bf)
    ) else $error("acknowledge without buffer load");

    no_ack_full_a: assert property ( // RL6
        (enabled && scl_fall && r.cnt == 4'h8 && r.state == i2cs_pkg::SL_DATA && r.bf
         && !start_det && !stop_det) |=> !r.ack && r.ctrl[6]
    ) else $error("byte taken while buffer full");

    read_clears_bf_a: assert property ( // RL9
        (acc && !pwrite && reg_hit(paddr, i2cs_pkg::IDX_RBUF) && !(scl_fall && r.cnt == 4'h8))
        |=> !r.bf
    ) else $error("buffer read did not clear full flag");

    addr_write_release_a: assert property ( // RL8
        (acc && pwrite && reg_hit(paddr, i2cs_pkg::IDX_OADDR) && !scl_fall)
        |=> !r.ua ##1 !r.scl_oe || !r.pdir[3]
    ) else $error("address write did not release clock");

    start_flags_a: assert property ( // RL14
        (enabled && start_det) |=> r.start_seen && !r.stop_seen
    ) else $error("start condition not recorded");

    disable_clears_a: assert property ( // RL14
        !enabled |=> !r.start_seen && !r.stop_seen && r.state == i2cs_pkg::SL_IDLE
    ) else $error("start or stop seen while disabled");

    sample_rise_a: assert property ( // RL2
        (enabled && scl_rise && r.cnt < 4'h8 && !start_det && !stop_det)
        |=> r.sr[0] == $past(sda_s)
    ) else $error("data bit not sampled on rising clock");

    master_idle_quiet_a: assert property ( // RL18
        (enabled && master_idle) [*3] |-> !r.ack && r.state == i2cs_pkg::SL_IDLE
    ) else $error("slave active in master idle mode");

    stop_irq_a: assert property ( // RL19
        (ss_irq && stop_det) |=> r.pflags[3] && r.stop_seen
    ) else $error("stop did not raise irq flag");

endmodule : i2cs_sync_serial_slave

// [design/i2cs_pkg.sv]
package i2cs_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int         ADDR_W     = 12;
    localparam logic [7:0] IDX_GIC    = 8'h0b;
    localparam logic [7:0] IDX_PFLAGS = 8'h0c;
    localparam logic [7:0] IDX_RBUF   = 8'h13;
    localparam logic [7:0] IDX_CTRL   = 8'h14;
    localparam logic [7:0] IDX_PDIR   = 8'h87;
    localparam logic [7:0] IDX_PEN    = 8'h8c;
    localparam logic [7:0] IDX_OADDR  = 8'h93;
    localparam logic [7:0] IDX_STAT   = 8'h94;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] RST_GIC    = 8'h00;
    localparam logic [7:0] RST_PFLAGS = 8'h00;
    localparam logic [7:0] RST_RBUF   = 8'h00;
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [7:0] RST_PDIR   = 8'hff;
    localparam logic [7:0] RST_PEN    = 8'h00;
    localparam logic [7:0] RST_OADDR  = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int GIE_BIT     = 7;
    localparam int PEIE_BIT    = 6;
    localparam int IRQ_BIT     = 3;
    localparam int OV_BIT      = 6;
    localparam int EN_BIT      = 5;
    localparam int SCL_DIR_BIT = 3;
    localparam int SDA_DIR_BIT = 4;
    localparam int BF_BIT      = 0;
    localparam int UA_BIT      = 1;
    localparam int RW_BIT      = 2;
    localparam int S_BIT       = 3;
    localparam int P_BIT       = 4;
    localparam int DA_BIT      = 5;

    // ------------------------------------------------------------
    // port_mode_select codes and bus constants
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_7BIT        = 4'h6;
    localparam logic [3:0] MODE_10BIT       = 4'h7;
    localparam logic [3:0] MODE_MASTER_IDLE = 4'hb;
    localparam logic [3:0] MODE_7BIT_SS     = 4'he;
    localparam logic [3:0] MODE_10BIT_SS    = 4'hf;
    localparam logic [4:0] TENBIT_PREFIX    = 5'h1e;
    localparam logic [3:0] BYTE_BITS        = 4'h8;
    localparam logic [3:0] ACK_CLOCK        = 4'h9;

    typedef enum logic [1:0] {SL_IDLE, SL_ADDR, SL_ADDR_LOW, SL_DATA} i2cs_slave_t;

    typedef struct packed {
        logic [7:0]  gic;
        logic [7:0]  pflags;
        logic [7:0]  rbuf;
        logic [7:0]  ctrl;
        logic [7:0]  pdir;
        logic [7:0]  pen;
        logic [7:0]  oaddr;
        logic [1:0]  smp_cke;
        logic        da;
        logic        stop_seen;
        logic        start_seen;
        logic        rw;
        logic        ua;
        logic        bf;
        logic [7:0]  sr;
        logic [3:0]  cnt;
        i2cs_slave_t state;
        logic        mine;
        logic        armed;
        logic        ack;
        logic        hold;
        logic        scl_oe;
        logic        sda_oe;
        logic        line_o;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } i2cs_state_t;

endpackage : i2cs_pkg

// [design/i2cs_pin_sync.sv]
// ------------------------------------------------------------
// two-stage synchroniser plus one delayed copy for edge finding
// ------------------------------------------------------------
module i2cs_pin_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      level,
    output logic      prev
);
    logic meta;

    // lines idle high, so reset to one to avoid a false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta  <= 1'b1;
            level <= 1'b1;
            prev  <= 1'b1;
        end else begin
            meta  <= din;
            level <= meta;
            prev  <= level;
        end
    end
endmodule : i2cs_pin_sync

// [verif/i2cs_bus_master.sv]
// ------------------------------------------------------------
// remote two-wire master: pulls lines low only, pull-ups do the rest
// ------------------------------------------------------------
module i2cs_bus_master (
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_pull,
    output logic      sda_pull
);
    timeunit 1ns;
    timeprecision 1ns;

    // both lines released at power up, so the bus looks idle
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    // start or repeated start; 30 ns offset keeps pin edges off pclk edges
    task automatic start();
        #30 sda_pull = 1'b0;
        #200 scl_pull = 1'b0;
        #200 sda_pull = 1'b1;
        #400 scl_pull = 1'b1;
        #170;
    endtask : start

    // msb first, 800 ns per bit; data moves only while the clock is low
    task automatic send_byte(input logic [7:0] b, output logic ack);
        #30;
        for (int i = 7; i >= 0; i--) begin
            sda_pull = ~b[i];
            #200 scl_pull = 1'b0;
            #400 scl_pull = 1'b1;
            #200;
        end
        sda_pull = 1'b0;
        #200 scl_pull = 1'b0;
        #200 ack = ~sda_line;
        #200 scl_pull = 1'b1;
        #170;
    endtask : send_byte

    // stop: data rises while the clock is high, then both stay released
    task automatic stop();
        #30 sda_pull = 1'b1;
        #200 scl_pull = 1'b0;
        #200 sda_pull = 1'b0;
        #370;
    endtask : stop
endmodule : i2cs_bus_master

// [verif/test_i2c_sync_serial_slave.sv]
// ------------------------------------------------------------
// register-level bench with a remote master on the wires
// ------------------------------------------------------------
module test_i2c_sync_serial_slave;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        scl_out, scl_oe, sda_out, sda_oe, irq, last_err, ack;
    logic        scl_pull, sda_pull, scl_line, sda_line;
    logic [7:0]  rd;
    int          err_total, n_compared;

    // wired-and with pull-ups: any party pulling wins
    assign scl_line = ~(scl_pull | scl_oe);
    assign sda_line = ~(sda_pull | sda_oe);

    i2cs_sync_serial_slave dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
    i2cs_bus_master m (.scl_line(scl_line), .sda_line(sda_line), .scl_pull(scl_pull),
        .sda_pull(sda_pull));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_total++;
            print_verdict();
        end
        rd       = prdata[7:0];
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd);
    endtask : wr

    task automatic rdm(input string what, input logic [7:0] idx, input logic [7:0] mask,
                       input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(what, rd & mask, exp);
    endtask : rdm

    // main sequence: reset values, pins, slave receive, ten-bit, master support
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        err_total = 0;
        n_compared = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdm("pflags rst", i2cs_pkg::IDX_PFLAGS, 8'hff, 8'h00);
        rdm("ctrl rst", i2cs_pkg::IDX_CTRL, 8'hff, 8'h00);
        rdm("pdir rst", i2cs_pkg::IDX_PDIR, 8'hff, 8'hff);
        rdm("pen rst", i2cs_pkg::IDX_PEN, 8'hff, 8'h00);
        rdm("oaddr rst", i2cs_pkg::IDX_OADDR, 8'hff, 8'h00);
        rdm("stat rst", i2cs_pkg::IDX_STAT, 8'hff, 8'h00);
        rdm("unmapped", 8'h00, 8'hff, 8'h00);
        chk("slverr", {7'h0, last_err}, 8'h01);
        // direction bit low pulls only its own line
        wr(i2cs_pkg::IDX_PDIR, 8'hef);
        repeat (2) @(posedge pclk);
        chk("sda pulled", {7'h0, sda_oe}, 8'h01);
        chk("scl free", {7'h0, scl_oe}, 8'h00);
        chk("outs low", {6'h0, scl_out, sda_out}, 8'h00);
        wr(i2cs_pkg::IDX_PDIR, 8'hff);
        wr(i2cs_pkg::IDX_OADDR, 8'h54);
        wr(i2cs_pkg::IDX_PEN, 8'h08);
        wr(i2cs_pkg::IDX_GIC, 8'hc0);
        wr(i2cs_pkg::IDX_CTRL, 8'h26);
        m.start();
        rdm("start seen", i2cs_pkg::IDX_STAT, 8'h18, 8'h08);
        m.send_byte(8'h54, ack);
        chk("addr ack", {7'h0, ack}, 8'h01);
        rdm("stat addr", i2cs_pkg::IDX_STAT, 8'h0f, 8'h09);
        rdm("flag addr", i2cs_pkg::IDX_PFLAGS, 8'hff, 8'h08);
        chk("irq pin", {7'h0, irq}, 8'h01);
        rdm("rbuf addr", i2cs_pkg::IDX_RBUF, 8'hff, 8'h54);
        rdm("bf cleared", i2cs_pkg::IDX_STAT, 8'h01, 8'h00);
        wr(i2cs_pkg::IDX_PFLAGS, 8'h00);
        m.send_byte(8'ha5, ack);
        chk("data ack", {7'h0, ack}, 8'h01);
        // second byte while still full is refused
        wr(i2cs_pkg::IDX_PFLAGS, 8'h00);
        m.send_byte(8'h3c, ack);
        chk("full nack", {7'h0, ack}, 8'h00);
        rdm("overflow", i2cs_pkg::IDX_CTRL, 8'hff, 8'h66);
        rdm("flag refused", i2cs_pkg::IDX_PFLAGS, 8'hff, 8'h08);
        rdm("rbuf kept", i2cs_pkg::IDX_RBUF, 8'hff, 8'ha5);
        m.stop();
        rdm("stop seen", i2cs_pkg::IDX_STAT, 8'h18, 8'h10);
        wr(i2cs_pkg::IDX_CTRL, 8'h00);
        rdm("disabled", i2cs_pkg::IDX_STAT, 8'h18, 8'h00);
        // another address must be ignored
        wr(i2cs_pkg::IDX_PFLAGS, 8'h00);
        wr(i2cs_pkg::IDX_CTRL, 8'h26);
        m.start();
        m.send_byte(8'h56, ack);
        chk("other nack", {7'h0, ack}, 8'h00);
        rdm("other flag", i2cs_pkg::IDX_PFLAGS, 8'hff, 8'h00);
        m.stop();
        // ten-bit high byte stretches the clock until the address is rewritten
        wr(i2cs_pkg::IDX_CTRL, 8'h27);
        wr(i2cs_pkg::IDX_OADDR, 8'hf6);
        m.start();
        m.send_byte(8'hf6, ack);
        chk("ten ack", {7'h0, ack}, 8'h01);
        rdm("update set", i2cs_pkg::IDX_STAT, 8'h03, 8'h03);
        chk("stretch", {7'h0, scl_oe}, 8'h01);
        wr(i2cs_pkg::IDX_OADDR, 8'h5a);
        repeat (2) @(posedge pclk);
        chk("released", {7'h0, scl_oe}, 8'h00);
        rdm("update clr", i2cs_pkg::IDX_STAT, 8'h02, 8'h00);
        m.stop();
        // slave idle, start and stop still raise the flag
        wr(i2cs_pkg::IDX_CTRL, 8'h2b);
        wr(i2cs_pkg::IDX_PFLAGS, 8'h00);
        m.start();
        rdm("flag start", i2cs_pkg::IDX_PFLAGS, 8'hff, 8'h08);
        wr(i2cs_pkg::IDX_PFLAGS, 8'h00);
        m.stop();
        rdm("flag stop", i2cs_pkg::IDX_PFLAGS, 8'hff, 8'h08);
        print_verdict();
    end
endmodule : test_i2c_sync_serial_slave
